// ### gl_pkg.sv
// Package of constants and types shared by the guard lock controller.
package gl_pkg;

   // ---------------------------------------------------------------
   // Bus and register map
   // ---------------------------------------------------------------
   localparam int unsigned AXI_AW = 4;
   localparam logic [3:0] OFS_CTRL     = 4'h0;
   localparam logic [3:0] OFS_STATUS   = 4'h4;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
   localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Control register fields.
   localparam int unsigned CTRL_MONITORED = 0;
   localparam int unsigned CTRL_SPRING    = 1;
   localparam int unsigned CTRL_MANDATORY = 2;
   localparam int unsigned CTRL_NO_DOOR   = 3;
   localparam int unsigned CTRL_FAULT_EN  = 4;
   localparam int unsigned CTRL_UNL_LSB   = 8;
   localparam int unsigned CTRL_FB_LSB    = 16;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET     = 32'h0000_0000;

   // Status register fields.
   localparam int unsigned STAT_MAIN   = 8;
   localparam int unsigned STAT_DRIVE  = 9;
   localparam int unsigned STAT_FAULT  = 10;
   localparam int unsigned STAT_OPENED = 11;
   localparam int unsigned STAT_CNT_LSB = 16;

   // Interrupt events.
   localparam int unsigned NUM_EV   = 4;
   localparam int unsigned EV_FAULT = 0;
   localparam int unsigned EV_LOCK  = 1;
   localparam int unsigned EV_OPEN  = 2;
   localparam int unsigned EV_RESET = 3;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 5;
   localparam int unsigned TICK_PERIOD_NS = 1_000_000;
   localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_W = 15;

   // Unlock delay code map, in milliseconds.
   localparam int unsigned UNL_FINE_LAST = 10;
   localparam int unsigned UNL_MID_LAST  = 28;
   localparam int unsigned UNL_FINE_MS   = 100;
   localparam int unsigned UNL_MID_BASE  = 1500;
   localparam int unsigned UNL_MID_MS    = 500;
   localparam int unsigned UNL_HI_BASE   = 15000;
   localparam int unsigned UNL_HI_MS     = 5000;

   // Feedback window code map, in milliseconds.
   localparam int unsigned FB_FINE_LAST = 9;
   localparam int unsigned FB_MID_LAST  = 27;
   localparam int unsigned FB_FINE_MS   = 10;
   localparam int unsigned FB_MID_BASE  = 150;
   localparam int unsigned FB_MID_MS    = 50;
   localparam int unsigned FB_HI_BASE   = 1500;
   localparam int unsigned FB_HI_MS     = 500;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [4:0] fb_code;
      logic [4:0] unl_code;
      logic       fault_en;
      logic       no_door;
      logic       mandatory;
      logic       spring;
      logic       monitored;
   } gl_cfg_t;

   typedef struct packed {
      logic reset_btn;
      logic lock_fbk;
      logic door_closed;
      logic unlock_req;
   } gl_pins_t;

   typedef enum logic [5:0] {
      ST_LOCKING   = 6'h01,
      ST_LOCKED    = 6'h02,
      ST_UNL_WAIT  = 6'h04,
      ST_UNLOCKING = 6'h08,
      ST_UNLOCKED  = 6'h10,
      ST_FAULT     = 6'h20
   } gl_state_t;

endpackage

// ### gl_sync.sv
// Two flip-flop synchroniser for the pin inputs.
`timescale 1ns/1ps
module gl_sync #(
   parameter int unsigned WIDTH = 4
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

// ### gl_guard_lock.sv
// Guard lock supervisor with AXI4-Lite registers and interrupt.
//
// Overview of operation
// - Check request, door and feedback for consistency.
// - Manual reset: one rising edge is valid.
// - Monitored reset: needs rise then fall.
// - Hold magnet for the selected unlock delay.
// - Feedback must follow drive within window.
// - Spring option: energised magnet means unlocked.
// - Mandatory opening: door must open then close.
// - No-door option: main output follows lock only.
// - Fault output high on lock malfunction.
// - Main output high only locked (and closed unless no-door).
// - Any error forces main output low.
// - One two-valued magnet drive output.
// - Request rise drops main output at once.
// - No-door mode relocks at once on release.
// - Main rises when feedback confirms lock.
`timescale 1ns/1ps
module gl_guard_lock #(
   parameter int unsigned TICK_CYCLES = gl_pkg::TICK_CYCLES_DEF
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [gl_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [gl_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      unlock_req,
   input  wire logic                      door_closed,
   input  wire logic                      lock_fbk,
   input  wire logic                      reset_btn,
   output logic                           main_out,
   output logic                           magnet_drive,
   output logic                           fault_flag,
   output logic                           irq
);
   import gl_pkg::*;

   localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

   // ---------------------------------------------------------------
   // Decoding helpers
   // ---------------------------------------------------------------
   function automatic logic [MS_W-1:0] unl_ms(input logic [4:0] c);
      int unsigned v;
      v = c;
      if (v <= UNL_FINE_LAST) begin
         return MS_W'(v * UNL_FINE_MS);
      end else if (v <= UNL_MID_LAST) begin
         return MS_W'(UNL_MID_BASE + (v - UNL_FINE_LAST - 1) * UNL_MID_MS);
      end
      return MS_W'(UNL_HI_BASE + (v - UNL_MID_LAST - 1) * UNL_HI_MS);
   endfunction

   function automatic logic [MS_W-1:0] fb_ms(input logic [4:0] c);
      int unsigned v;
      v = c;
      if (v <= FB_FINE_LAST) begin
         return MS_W'((v + 1) * FB_FINE_MS);
      end else if (v <= FB_MID_LAST) begin
         return MS_W'(FB_MID_BASE + (v - FB_FINE_LAST - 1) * FB_MID_MS);
      end
      return MS_W'(FB_HI_BASE + (v - FB_MID_LAST - 1) * FB_HI_MS);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic gl_cfg_t to_cfg(input logic [31:0] r);
      gl_cfg_t c;
      c.monitored = r[CTRL_MONITORED];
      c.spring    = r[CTRL_SPRING];
      c.mandatory = r[CTRL_MANDATORY];
      c.no_door   = r[CTRL_NO_DOOR];
      c.fault_en  = r[CTRL_FAULT_EN];
      c.unl_code  = r[CTRL_UNL_LSB +: 5];
      c.fb_code   = r[CTRL_FB_LSB +: 5];
      return c;
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   gl_pins_t pin;
   gl_pins_t pin_raw;

   assign pin_raw = '{reset_btn: reset_btn, lock_fbk: lock_fbk,
                      door_closed: door_closed, unlock_req: unlock_req};

   gl_sync #(
      .WIDTH ($bits(gl_pins_t))
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (pin_raw),
      .dout    (pin)
   );

   // ---------------------------------------------------------------
   // Control state
   // ---------------------------------------------------------------
   gl_state_t         state;
   gl_state_t         next_state;
   gl_cfg_t           cfg;
   gl_cfg_t           next_cfg;
   logic              cfg_taken;
   logic              next_cfg_taken;
   logic [TICK_W-1:0] tick_cnt;
   logic [TICK_W-1:0] next_tick_cnt;
   logic [MS_W-1:0]   ms_cnt;
   logic [MS_W-1:0]   next_ms_cnt;
   logic              next_drive;
   logic              next_main;
   logic              next_fault;
   logic              door_opened;
   logic              next_door_opened;
   logic              btn_q;
   logic              btn_armed;
   logic              next_btn_armed;
   logic [NUM_EV-1:0] ev;
   logic [31:0]       ctrl;
   logic              tick;
   logic              drive_lock;
   logic              fbk_locked;
   logic              door_ok;
   logic              rst_ok;
   logic              fb_over;

   always_comb begin
      next_state       = state;
      next_cfg         = cfg;
      next_cfg_taken   = 1'b1;
      next_drive       = magnet_drive;
      next_door_opened = door_opened;
      next_btn_armed   = btn_armed;
      ev               = '0;
      tick             = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
      next_tick_cnt    = tick ? '0 : tick_cnt + 1'b1;
      next_ms_cnt      = (tick && ms_cnt != '1) ? ms_cnt + 1'b1 : ms_cnt;
      drive_lock       = ~cfg.spring;
      fbk_locked       = (pin.lock_fbk == drive_lock);
      door_ok          = cfg.no_door | pin.door_closed;
      fb_over          = (ms_cnt >= fb_ms(cfg.fb_code));
      // A manual reset is a rise; a monitored one needs the fall too.
      if (pin.reset_btn && !btn_q) begin
         next_btn_armed = 1'b1;
      end else if (!pin.reset_btn && btn_q) begin
         next_btn_armed = 1'b0;
      end
      rst_ok = cfg.monitored ? (btn_armed && !pin.reset_btn && btn_q)
                             : (pin.reset_btn && !btn_q);
      // Options are taken once after reset, then again on each restart.
      if (!cfg_taken) begin
         next_cfg = to_cfg(ctrl);
      end
      unique case (state)
         ST_LOCKING: begin
            next_drive = drive_lock;
            if (pin.unlock_req) begin
               next_state = ST_UNL_WAIT;
            end else if (fbk_locked && door_ok) begin
               next_state = ST_LOCKED;
            end else if (fb_over) begin
               // Door is judged only at window end: the synchroniser
               // shows it open for two cycles after reset.
               next_state = ST_FAULT;
            end
         end
         ST_LOCKED: begin
            if (!fbk_locked || !door_ok) begin
               next_state = ST_FAULT;
            end else if (pin.unlock_req) begin
               next_state = ST_UNL_WAIT;
            end
         end
         ST_UNL_WAIT: begin
            if (!fbk_locked || !door_ok) begin
               next_state = ST_FAULT;
            end else if (!pin.unlock_req) begin
               next_state = ST_LOCKING;
            end else if (ms_cnt >= unl_ms(cfg.unl_code)) begin
               next_state = ST_UNLOCKING;
               next_drive = ~drive_lock;
            end
         end
         ST_UNLOCKING: begin
            if (!fbk_locked) begin
               next_state = ST_UNLOCKED;
            end else if (fb_over) begin
               next_state = ST_FAULT;
            end
         end
         ST_UNLOCKED: begin
            if (!pin.door_closed) begin
               next_door_opened = 1'b1;
            end
            if (fbk_locked) begin
               next_state = ST_FAULT;
            end else if (!pin.unlock_req) begin
               if (cfg.no_door) begin
                  next_state = ST_LOCKING;
                  next_drive = drive_lock;
               end else if (pin.door_closed
                            && (!cfg.mandatory || door_opened)) begin
                  next_state = ST_LOCKING;
                  next_drive = drive_lock;
               end
            end
         end
         ST_FAULT: begin
            next_drive = drive_lock;
            if (rst_ok) begin
               next_state = ST_LOCKING;
               next_cfg   = to_cfg(ctrl);
               ev[EV_RESET] = 1'b1;
            end
         end
      endcase
      if (next_state != state) begin
         next_ms_cnt   = '0;
         next_tick_cnt = '0;
      end
      if (next_state == ST_LOCKING) begin
         next_door_opened = 1'b0;
      end
      ev[EV_FAULT] = (next_state == ST_FAULT) && (state != ST_FAULT);
      ev[EV_LOCK]  = (next_state == ST_LOCKED) && (state != ST_LOCKED);
      ev[EV_OPEN]  = (next_state == ST_UNLOCKED) && (state != ST_UNLOCKED);
      next_main  = (next_state == ST_LOCKED);
      next_fault = (next_state == ST_FAULT) && cfg.fault_en;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state        <= ST_LOCKING;
         cfg          <= '0;
         cfg_taken    <= 1'b0;
         tick_cnt     <= '0;
         ms_cnt       <= '0;
         magnet_drive <= 1'b1;
         main_out     <= 1'b0;
         fault_flag   <= 1'b0;
         door_opened  <= 1'b0;
         btn_q        <= 1'b0;
         btn_armed    <= 1'b0;
      end else begin
         state        <= next_state;
         cfg          <= next_cfg;
         cfg_taken    <= next_cfg_taken;
         tick_cnt     <= next_tick_cnt;
         ms_cnt       <= next_ms_cnt;
         magnet_drive <= next_drive;
         main_out     <= next_main;
         fault_flag   <= next_fault;
         door_opened  <= next_door_opened;
         btn_q        <= pin.reset_btn;
         btn_armed    <= next_btn_armed;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite slave and interrupt registers
   // ---------------------------------------------------------------
   logic [AXI_AW-1:0] aw_addr;
   logic [AXI_AW-1:0] next_aw_addr;
   logic              aw_full;
   logic              next_aw_full;
   logic [31:0]       w_data;
   logic [31:0]       next_w_data;
   logic [3:0]        w_strb;
   logic [3:0]        next_w_strb;
   logic              w_full;
   logic              next_w_full;
   logic              next_bvalid;
   logic [1:0]        next_bresp;
   logic              next_rvalid;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;
   logic [31:0]       next_ctrl;
   logic [NUM_EV-1:0] irq_stat;
   logic [NUM_EV-1:0] next_irq_stat;
   logic [NUM_EV-1:0] irq_mask;
   logic [NUM_EV-1:0] next_irq_mask;
   logic [NUM_EV-1:0] clr;
   logic [31:0]       status;

   always_comb begin
      status = '0;
      status[$bits(gl_state_t)-1:0] = state;
      status[STAT_MAIN]   = main_out;
      status[STAT_DRIVE]  = magnet_drive;
      status[STAT_FAULT]  = (state == ST_FAULT);
      status[STAT_OPENED] = door_opened;
      status[STAT_CNT_LSB +: MS_W] = ms_cnt;
   end

   always_comb begin
      next_aw_addr  = aw_addr;
      next_aw_full  = aw_full;
      next_w_data   = w_data;
      next_w_strb   = w_strb;
      next_w_full   = w_full;
      next_bvalid   = s_axi_bvalid;
      next_bresp    = s_axi_bresp;
      next_rvalid   = s_axi_rvalid;
      next_rdata    = s_axi_rdata;
      next_rresp    = s_axi_rresp;
      next_ctrl     = ctrl;
      next_irq_mask = irq_mask;
      clr           = '0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_addr = s_axi_awaddr;
         next_aw_full = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
         next_w_full = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_full && w_full && !s_axi_bvalid) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OKAY;
         unique case (aw_addr)
            OFS_CTRL:     next_ctrl = merge(ctrl, w_data, w_strb);
            OFS_STATUS:   ;
            OFS_IRQ_STAT: clr = NUM_EV'(merge('0, w_data, w_strb));
            OFS_IRQ_MASK: next_irq_mask = NUM_EV'(merge(32'(irq_mask),
                                                        w_data, w_strb));
            default:      next_bresp = RESP_DECERR;
         endcase
      end
      // A new event wins over a clear written in the same cycle.
      next_irq_stat = (irq_stat & ~clr) | ev;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_CTRL:     next_rdata = ctrl;
            OFS_STATUS:   next_rdata = status;
            OFS_IRQ_STAT: next_rdata = 32'(irq_stat);
            OFS_IRQ_MASK: next_rdata = 32'(irq_mask);
            default: begin
               next_rdata = '0;
               next_rresp = RESP_DECERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr       <= '0;
         aw_full       <= 1'b0;
         w_data        <= '0;
         w_strb        <= '0;
         w_full        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
         ctrl          <= CTRL_RESET;
         irq_stat      <= '0;
         irq_mask      <= NUM_EV'(MASK_RESET);
         irq           <= 1'b0;
      end else begin
         aw_addr       <= next_aw_addr;
         aw_full       <= next_aw_full;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         w_full        <= next_w_full;
         s_axi_awready <= !next_aw_full;
         s_axi_wready  <= !next_w_full;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
         ctrl          <= next_ctrl;
         irq_stat      <= next_irq_stat;
         irq_mask      <= next_irq_mask;
         irq           <= |(next_irq_stat & next_irq_mask);
      end
   end

endmodule

// ### gl_lock_model.sv
// Behavioural electromagnetic lock with a delayed feedback contact.
`timescale 1ns/1ps
module gl_lock_model (
   input  wire logic        aclk,
   input  wire logic        magnet_drive,
   input  wire logic        stuck,
   input  wire logic [15:0] act_dly,
   output logic             lock_fbk
);
   int unsigned cnt = 0;
   initial lock_fbk = 1'b0;
   // The contact follows the coil only after the activation time; a stuck
   // contact models a welded switch and never follows.
   always @(posedge aclk) begin
      if (stuck || lock_fbk == magnet_drive) begin
         cnt <= 0;
      end else if (cnt + 1 >= act_dly) begin
         lock_fbk <= magnet_drive;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// ### gl_guard_lock_chk.sv
// Checker of the guard lock controller's port behaviour.
`timescale 1ns/1ps
module gl_guard_lock_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        unlock_req,
   input wire logic        lock_fbk,
   input wire logic        reset_btn,
   input wire logic        main_out,
   input wire logic        magnet_drive,
   input wire logic        fault_flag,
   input wire logic        irq
);
   logic [2:0] low_cnt;
   logic [2:0] next_low_cnt;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Counts cycles with the button released, so a pending release that is
   // still inside the synchroniser is never mistaken for a quiet button.
   always_comb begin
      next_low_cnt = low_cnt;
      if (reset_btn) begin
         next_low_cnt = 3'h0;
      end else if (low_cnt != 3'h7) begin
         next_low_cnt = low_cnt + 3'h1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_cnt <= 3'h0;
      end else begin
         low_cnt <= next_low_cnt;
      end
   end
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   chk_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   chk_unlock_low: assert property (unlock_req [*4] |-> !main_out)
      else $error("main high under request");
   chk_fault_main: assert property (fault_flag |-> !main_out)
      else $error("main high in fault");
   chk_main_fbk: assert property (main_out |->
      $past(lock_fbk, 3) == magnet_drive) else $error("main without lock");
   chk_fault_hold: assert property (fault_flag && low_cnt == 3'h7 |=>
      fault_flag) else $error("fault left without reset");
   cover property ($rose(fault_flag));
   cover property ($rose(main_out));
   cover property ($rose(irq));
endmodule

bind gl_guard_lock gl_guard_lock_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .unlock_req, .lock_fbk,
   .reset_btn, .main_out, .magnet_drive, .fault_flag, .irq);

// ### gl_guard_lock_tb.sv
// Self-checking testbench of the guard lock controller.
`timescale 1ns/1ps
module gl_guard_lock_tb;
   logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, unlock_req = 1'b0, door_closed = 1'b1;
   logic        reset_btn = 1'b0, stuck = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [15:0] act_dly = 16'h0014;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, lock_fbk, main_out, magnet_drive, fault_flag, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [33:0] exp_q[$];
   int          error_cnt = 0, num_checks = 0, cyc = 0;

   gl_guard_lock #(.TICK_CYCLES(10)) dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unlock_req,
      .door_closed, .lock_fbk, .reset_btn, .main_out, .magnet_drive,
      .fault_flag, .irq);
   gl_lock_model u_lock (.aclk, .magnet_drive, .stuck, .act_dly, .lock_fbk);

   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic final_report();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Each channel is released at the edge that takes it.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      exp_q.push_back({a == 4'h2 ? 2'h3 : 2'h0, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   initial begin
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      void'($urandom(25045));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      act_dly <= 16'(20 + $urandom % 60);
      repeat (400) if (main_out !== 1'b1) @(posedge aclk);
      chk(main_out, 1'b1);
      chk(magnet_drive, 1'b1);
      wr(4'hc, 32'hf);
      rd(4'hc, 34'hf);
      rd(4'h8, 34'h2);
      chk(irq, 1'b1);
      wr(4'h8, 32'h2);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b0);
      rd(4'h2, {2'h3, 32'h0});
      wr(4'h2, 32'h1);
      wr(4'h0, 32'h0002_0115);
      rd(4'h0, 34'h0002_0115);
      door_closed <= 1'b0;
      repeat (8) @(posedge aclk);
      chk(main_out, 1'b0);
      chk(fault_flag, 1'b0);
      door_closed <= 1'b1;
      repeat (10) @(posedge aclk);
      chk(main_out, 1'b0);
      reset_btn <= 1'b1;
      repeat (400) if (main_out !== 1'b1) @(posedge aclk);
      chk(main_out, 1'b1);
      reset_btn <= 1'b0;
      rd(4'h8, 34'hb);
      unlock_req <= 1'b1;
      repeat (5) @(posedge aclk);
      chk(main_out, 1'b0);
      repeat (880) @(posedge aclk);
      chk(magnet_drive, 1'b1);
      repeat (240) if (magnet_drive !== 1'b0) @(posedge aclk);
      chk(magnet_drive, 1'b0);
      repeat (100) @(posedge aclk);
      door_closed <= 1'b0;
      repeat (20) @(posedge aclk);
      chk(main_out, 1'b0);
      door_closed <= 1'b1;
      unlock_req <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(magnet_drive, 1'b1);
      repeat (400) if (main_out !== 1'b1) @(posedge aclk);
      chk(main_out, 1'b1);
      stuck <= 1'b1;
      unlock_req <= 1'b1;
      repeat (1500) if (fault_flag !== 1'b1) @(posedge aclk);
      chk(fault_flag, 1'b1);
      chk(main_out, 1'b0);
      wr(4'h0, 32'h0002_011b);
      unlock_req <= 1'b0;
      stuck <= 1'b0;
      door_closed <= 1'b0;
      reset_btn <= 1'b1;
      repeat (10) @(posedge aclk);
      chk(fault_flag, 1'b1);
      reset_btn <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(magnet_drive, 1'b0);
      repeat (400) if (main_out !== 1'b1) @(posedge aclk);
      chk(main_out, 1'b1);
      chk(fault_flag, 1'b0);
      unlock_req <= 1'b1;
      repeat (1200) if (magnet_drive !== 1'b1) @(posedge aclk);
      chk(magnet_drive, 1'b1);
      repeat (100) @(posedge aclk);
      unlock_req <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(magnet_drive, 1'b0);
      final_report();
   end
endmodule
